// ### pkg/rtc_osc_regs.vh
`ifndef RTC_OSC_REGS_VH
`define RTC_OSC_REGS_VH

// Internal addresses behind the indirect port pair
`define ROC_ADDR_CONTROL   4'h6
`define ROC_ADDR_OSC_CTRL  4'h7

// Control register fields
`define ROC_CTL_POWER_EN   7
`define ROC_CTL_MISS_EN    6
`define ROC_CTL_FAIL       5
`define ROC_CTL_TIMER_RUN  4
`define ROC_CTL_ALARM_EN   3
`define ROC_CTL_ALARM      2
`define ROC_CTL_LOAD       1
`define ROC_CTL_SNAPSHOT   0
`define ROC_CTL_RESET      8'h00

// Oscillator control register fields
`define ROC_OSC_GAIN_EN    7
`define ROC_OSC_MODE       6
`define ROC_OSC_BIAS_X2    5
`define ROC_OSC_VALID      4
`define ROC_OSC_RESET      8'h00

// Missing-clock timeout: 50 us at a 10 ns core clock period
`define ROC_MISS_TIME_NS   50000
`define ROC_CLK_PERIOD_NS  10
`define ROC_MISS_CYCLES    (`ROC_MISS_TIME_NS / `ROC_CLK_PERIOD_NS)

`endif

// ### hw/roc_ctrl.v
// Contract
// - Timebase clock comes from its own oscillator, unrelated to the core clock.
// - Crystal mode runs 32.768 kHz; self-oscillate runs about 20 or 40 kHz.
// - Mode select zero picks self-oscillate; bias double picks 20 or 40 kHz.
// - Gain control enable bit 7 lets the oscillator trim its amplitude.
// - Bias double bit 5 doubles bias current, raising self-oscillate frequency.
// - Missing-clock enable bit 6 arms the one-shot detector; zero disables.
// - Armed detector sets fail flag bit 5 after 50 us without an edge.
// - Timeout wakes oscillator, raises interrupt if enabled, resets core if enabled.
// - Power enable bit 7 gates bias and oscillator and allows backup supply.
`include "rtc_osc_regs.vh"
`default_nettype none

module roc_ctrl #(
	parameter MISS_CYCLES = `ROC_MISS_CYCLES
) (
	input  wire       mclk,
	input  wire       resetn,
	input  wire       addr_wr,
	input  wire [3:0] addr_wdata,
	input  wire       data_wr,
	input  wire [7:0] data_wdata,
	output reg  [3:0] addr_rdata,
	output reg  [7:0] data_rdata,
	input  wire       rtc_timebase_clock,
	input  wire       osc_clock_valid,
	input  wire       alarm_event,
	input  wire       load_done,
	input  wire       snapshot_done,
	input  wire       irq_enable,
	input  wire       reset_source_enable,
	output reg        rtc_power_enable,
	output reg        backup_switch_allow,
	output reg        osc_mode_select,
	output reg        gain_control_enable,
	output reg        bias_double,
	output reg        timer_run,
	output reg        alarm_enable,
	output reg        timer_load_trigger,
	output reg        timer_snapshot_trigger,
	output reg        osc_fail_flag,
	output reg        alarm_flag,
	output reg        osc_wake_pulse,
	output reg        core_reset_pulse,
	output wire       rtc_irq_request
);

	localparam CW = 16;
	localparam [CW-1:0] MISS_LIMIT = MISS_CYCLES[CW-1:0];

	reg  [3:0]    addr_ff;
	reg           tb_meta_ff;
	reg           tb_sync_ff;
	reg           tb_last_ff;
	reg           vld_meta_ff;
	reg           vld_sync_ff;
	reg           miss_en_ff;
	reg  [CW-1:0] stall_ff;
	reg           fired_ff;
	reg  [7:0]    nxt_rdata;
	wire          tb_edge;
	wire          timeout;
	wire          wr_ctl;
	wire          wr_osc;
	wire [7:0]    ctl_view;
	wire [7:0]    osc_view;

	function addr_hit;
		input [3:0] a;
		input [3:0] target;
		begin
			addr_hit = (a == target);
		end
	endfunction

	assign wr_ctl = data_wr & addr_hit(addr_ff, `ROC_ADDR_CONTROL);
	assign wr_osc = data_wr & addr_hit(addr_ff, `ROC_ADDR_OSC_CTRL);

	// Address port
	always @(posedge mclk)
	begin
		if (!resetn)
			addr_ff <= 4'h0;
		else if (addr_wr)
			addr_ff <= addr_wdata;
	end

	always @*
	begin
		addr_rdata = addr_ff;
	end

	// The timebase is foreign to the core clock, so it is synchronised first
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			tb_meta_ff  <= 1'b0;
			tb_sync_ff  <= 1'b0;
			tb_last_ff  <= 1'b0;
			vld_meta_ff <= 1'b0;
			vld_sync_ff <= 1'b0;
		end
		else
		begin
			tb_meta_ff  <= rtc_timebase_clock;
			tb_sync_ff  <= tb_meta_ff;
			tb_last_ff  <= tb_sync_ff;
			vld_meta_ff <= osc_clock_valid;
			vld_sync_ff <= vld_meta_ff;
		end
	end

	assign tb_edge = tb_sync_ff ^ tb_last_ff;

	// Stall timer on the core clock; either edge restarts it
	always @(posedge mclk)
	begin
		if (!resetn)
			stall_ff <= {CW{1'b0}};
		else if (!miss_en_ff || tb_edge)
			stall_ff <= {CW{1'b0}};
		else if (stall_ff != MISS_LIMIT)
			stall_ff <= stall_ff + {{(CW-1){1'b0}}, 1'b1};
	end

	// One-shot: fires once per stall, rearmed by the next edge
	assign timeout = miss_en_ff & ~tb_edge & ~fired_ff & (stall_ff == MISS_LIMIT);

	always @(posedge mclk)
	begin
		if (!resetn)
			fired_ff <= 1'b0;
		else if (!miss_en_ff || tb_edge)
			fired_ff <= 1'b0;
		else if (timeout)
			fired_ff <= 1'b1;
	end

	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			osc_wake_pulse   <= 1'b0;
			core_reset_pulse <= 1'b0;
		end
		else
		begin
			osc_wake_pulse   <= timeout;
			core_reset_pulse <= timeout & reset_source_enable;
		end
	end

	assign rtc_irq_request = osc_fail_flag & irq_enable;

	// Control register
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			rtc_power_enable       <= 1'b0;
			backup_switch_allow    <= 1'b0;
			miss_en_ff             <= 1'b0;
			timer_run              <= 1'b0;
			alarm_enable           <= 1'b0;
			timer_load_trigger     <= 1'b0;
			timer_snapshot_trigger <= 1'b0;
		end
		else
		begin
			if (wr_ctl)
			begin
				rtc_power_enable    <= data_wdata[`ROC_CTL_POWER_EN];
				backup_switch_allow <= data_wdata[`ROC_CTL_POWER_EN];
				miss_en_ff          <= data_wdata[`ROC_CTL_MISS_EN];
				timer_run           <= data_wdata[`ROC_CTL_TIMER_RUN];
				alarm_enable        <= data_wdata[`ROC_CTL_ALARM_EN];
			end
			// Transfer requests stay up until the timer logic reports completion
			if (wr_ctl && data_wdata[`ROC_CTL_LOAD])
				timer_load_trigger <= 1'b1;
			else if (load_done)
				timer_load_trigger <= 1'b0;
			if (wr_ctl && data_wdata[`ROC_CTL_SNAPSHOT])
				timer_snapshot_trigger <= 1'b1;
			else if (snapshot_done)
				timer_snapshot_trigger <= 1'b0;
		end
	end

	// Sticky flags: a set in the same cycle as a software clear wins
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			osc_fail_flag <= 1'b0;
			alarm_flag    <= 1'b0;
		end
		else
		begin
			if (timeout)
				osc_fail_flag <= 1'b1;
			else if (wr_ctl && !data_wdata[`ROC_CTL_FAIL])
				osc_fail_flag <= 1'b0;
			if (alarm_event)
				alarm_flag <= 1'b1;
			else if (wr_ctl && !data_wdata[`ROC_CTL_ALARM])
				alarm_flag <= 1'b0;
		end
	end

	// Oscillator control register; settings go straight to the analog cell
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			gain_control_enable <= 1'b0;
			osc_mode_select     <= 1'b0;
			bias_double         <= 1'b0;
		end
		else if (wr_osc)
		begin
			gain_control_enable <= data_wdata[`ROC_OSC_GAIN_EN];
			osc_mode_select     <= data_wdata[`ROC_OSC_MODE];
			bias_double         <= data_wdata[`ROC_OSC_BIAS_X2];
		end
	end
	// Self-oscillate needs no settling, so the valid flag is simply reported

	assign ctl_view = {rtc_power_enable, miss_en_ff, osc_fail_flag, timer_run,
		alarm_enable, alarm_flag, timer_load_trigger, timer_snapshot_trigger};
	assign osc_view = {gain_control_enable, osc_mode_select, bias_double,
		vld_sync_ff, 4'h0};

	always @*
	begin
		nxt_rdata = 8'h00;
		case (addr_ff)
			`ROC_ADDR_CONTROL:  nxt_rdata = ctl_view;
			`ROC_ADDR_OSC_CTRL: nxt_rdata = osc_view;
			default:            nxt_rdata = 8'h00;
		endcase
	end

	// Read data refreshes every cycle from the current address
	always @(posedge mclk)
	begin
		if (!resetn)
			data_rdata <= 8'h00;
		else
			data_rdata <= nxt_rdata;
	end

endmodule

`default_nettype wire

// ### testbench/roc_ctrl_sva.sv
`default_nettype none
module roc_ctrl_sva #(parameter MISS_CYCLES = 5000) (
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       data_wr,
	input wire logic [7:0] data_wdata,
	input wire logic [3:0] addr_rdata,
	input wire logic       rtc_timebase_clock,
	input wire logic       irq_enable,
	input wire logic       osc_fail_flag,
	input wire logic       osc_wake_pulse,
	input wire logic       core_reset_pulse,
	input wire logic       rtc_irq_request
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        arm_ff;
	logic        edge_ff;
	logic [15:0] stall_ff;
	wire         ctl_wr = data_wr && addr_rdata == 4'h6;
	// Raw pin count leads the synced count, so during a stall it is never below it
	always_ff @(posedge mclk)
	begin
		edge_ff <= rtc_timebase_clock;
		arm_ff <= resetn && (ctl_wr ? data_wdata[6] : arm_ff);
		stall_ff <= (arm_ff && edge_ff == rtc_timebase_clock) ? stall_ff + 16'h1 : 16'h0;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_one_pulse;
		osc_wake_pulse ##1 !osc_wake_pulse;
	endsequence
	chk_irq_gate: assert property (rtc_irq_request == (osc_fail_flag && irq_enable))
		else $error("irq gate");
	chk_reset_wake: assert property (core_reset_pulse |-> osc_wake_pulse)
		else $error("reset without wake");
	chk_wake_once: assert property ($rose(osc_wake_pulse) |-> s_one_pulse)
		else $error("wake not one cycle");
	chk_wake_flag: assert property (osc_wake_pulse |-> osc_fail_flag)
		else $error("wake without flag");
	chk_fail_sticky: assert property (osc_fail_flag && !(ctl_wr && !data_wdata[5]) |=> osc_fail_flag)
		else $error("flag lost");
	chk_no_early: assert property ($rose(osc_fail_flag) |-> stall_ff >= MISS_CYCLES)
		else $error("early fail");
	chk_timeout_due: assert property (stall_ff == MISS_CYCLES + 6 |-> osc_fail_flag)
		else $error("late fail");
	chk_fail_clear: assert property (ctl_wr && !data_wdata[5] && stall_ff < MISS_CYCLES |=> !osc_fail_flag)
		else $error("flag not cleared");
endmodule
bind roc_ctrl roc_ctrl_sva #(.MISS_CYCLES(MISS_CYCLES)) roc_ctrl_sva_i (.mclk, .resetn,
	.data_wr, .data_wdata, .addr_rdata, .rtc_timebase_clock, .irq_enable, .osc_fail_flag,
	.osc_wake_pulse, .core_reset_pulse, .rtc_irq_request);
`default_nettype wire

// ### testbench/roc_osc_model.sv
`default_nettype none
module roc_osc_model (
	input  wire logic mclk,
	input  wire logic power,
	input  wire logic mode,
	input  wire logic bias,
	input  wire logic stop,
	output var  logic osc_out,
	output wire logic valid
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	int edges = 0;
	initial osc_out = 1'b0;
	// Rates scaled to short mclk counts; bias doubling halves the half period
	always @(posedge mclk)
	begin
		cnt <= cnt + 1;
		if (power && !stop && cnt >= (mode ? 7 : bias ? 4 : 9))
		begin
			cnt <= 0;
			osc_out <= ~osc_out;
			edges <= edges + 1;
		end
	end
	assign valid = power && (!mode || edges > 8);
endmodule
`default_nettype wire

// ### testbench/tb_roc_ctrl.sv
`default_nettype none
module tb_roc_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, resetn = 0, aw = 0, dw = 0, ien = 0, ren = 0, stop = 0;
	logic        ae = 0, ld = 0, sd = 0, ltr, str, alm;
	logic [3:0]  aw_d = 0, ar;
	logic [7:0]  dw_d = 0, dr, rd, ov;
	logic        tbc, vld, pwr, bkp, mode, gain, bias, trun, aen, fail, wake, crst, irq;
	logic [31:0] r = 32'he5b19ef2;
	int          fail_count = 0, samples_checked = 0, i;
	roc_ctrl #(.MISS_CYCLES(20)) roc_ctrl_i (.mclk, .resetn, .addr_wr(aw), .addr_wdata(aw_d),
		.addr_rdata(ar), .data_wr(dw), .data_wdata(dw_d), .data_rdata(dr),
		.rtc_timebase_clock(tbc), .osc_clock_valid(vld), .alarm_event(ae), .load_done(ld),
		.snapshot_done(sd), .irq_enable(ien), .reset_source_enable(ren),
		.rtc_power_enable(pwr), .backup_switch_allow(bkp), .osc_mode_select(mode),
		.gain_control_enable(gain), .bias_double(bias), .timer_run(trun), .alarm_enable(aen),
		.timer_load_trigger(ltr), .timer_snapshot_trigger(str), .osc_fail_flag(fail),
		.alarm_flag(alm),
		.osc_wake_pulse(wake), .core_reset_pulse(crst), .rtc_irq_request(irq));
	roc_osc_model roc_osc_model_i (.mclk, .power(pwr), .mode, .bias, .stop, .osc_out(tbc),
		.valid(vld));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] exp_osc(input logic [7:0] v);
		return {v[7:5], 5'h10};
	endfunction
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		aw = 1;
		aw_d = a;
		@(negedge mclk) aw = 0;
		dw = 1;
		dw_d = d;
		@(negedge mclk) dw = 0;
	endtask
	task automatic rd_reg(input logic [3:0] a);
		aw = 1;
		aw_d = a;
		@(negedge mclk) aw = 0;
		// Ends without touching aw so a following call may raise it at once
		repeat (2) @(negedge mclk);
		rd = dr;
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial forever #5 mclk = ~mclk;
	initial
	begin
		#50000;
		fail_count++;
		complete_run;
	end
	initial
	begin
		repeat (4) @(negedge mclk);
		resetn = 1;
		chk("out", {2'h0, pwr, bkp, fail, wake, crst, irq}, 8'h00);
		wr(4'h3, 8'hff);
		rd_reg(4'h3);
		chk("gap", rd, 8'h00);
		rd_reg(4'h6);
		chk("ctl", rd, 8'h00);
		chk("adr", {4'h0, ar}, 8'h06);
		wr(4'h7, 8'he0);
		wr(4'h6, 8'h80);
		chk("pwr", {6'h0, pwr, bkp}, 8'h03);
		for (i = 0; i < 40 && rd[4] !== 1'b1; i++) rd_reg(4'h7);
		chk("osc", rd, 8'hf0);
		// Power stays on so the valid bit is steady through the random sweep
		for (i = 0; i < 12; i++)
		begin
			r = xs(r);
			ien = r[16];
			// Gain control only ever goes on together with crystal mode
			ov = r[7:0] & {r[6], 7'h7f};
			wr(4'h7, ov);
			chk("opt", {5'h0, gain, mode, bias}, {5'h0, ov[7:5]});
			rd_reg(4'h7);
			chk("osc", rd, exp_osc(ov));
			wr(4'h6, r[15:8] & 8'h18 | 8'h80);
			rd_reg(4'h6);
			chk("ctl", {trun, aen, rd[5:0]}, {r[12:11], r[13:8] & 6'h18});
		end
		wr(4'h7, 8'h40);
		ien = 1;
		ren = 1;
		wr(4'h6, 8'hc0);
		repeat (60) @(negedge mclk);
		chk("live", {7'h0, fail}, 8'h00);
		stop = 1;
		for (i = 0; i < 60 && wake !== 1'b1; i++) @(negedge mclk);
		chk("evt", {4'h0, wake, fail, crst, irq}, 8'h0f);
		wr(4'h6, 8'he0);
		rd_reg(4'h6);
		chk("hold", rd, 8'he0);
		stop = 0;
		repeat (20) @(negedge mclk);
		wr(4'h6, 8'hc0);
		rd_reg(4'h6);
		chk("clr", {rd[7:1], irq}, 8'hc0);
		wr(4'h6, 8'h80);
		stop = 1;
		repeat (60) @(negedge mclk);
		chk("off", {7'h0, fail}, 8'h00);
		stop = 0;
		wr(4'h6, 8'h83);
		chk("trig", {6'h0, ltr, str}, 8'h03);
		ld = 1;
		ae = 1;
		@(negedge mclk) ld = 0;
		ae = 0;
		sd = 1;
		@(negedge mclk) sd = 0;
		rd_reg(4'h6);
		chk("done", rd, 8'h84);
		wr(4'h6, 8'h84);
		chk("alm", {7'h0, alm}, 8'h01);
		wr(4'h6, 8'h80);
		chk("aclr", {7'h0, alm}, 8'h00);
		complete_run;
	end
endmodule
`default_nettype wire
